// file: lcb_defines.svh
// Opcodes, special byte addresses, status bits and reset values for the logic/compare/BCD datapath
// What this block does
// RULE1: AND register/direct/indirect into accumulator, flags kept
// RULE2: AND immediate second byte into accumulator
// RULE3: AND accumulator or immediate into direct byte
// RULE4: Port read-modify-write uses output latch
// RULE5: Bit AND clears carry on zero bit
// RULE6: Slashed bit AND uses inverted bit
// RULE7: Compare branch adds 3, then displacement
// RULE8: Compare sets carry on unsigned less-than
// RULE9: Four compare forms, each three bytes
// RULE10: Clear accumulator, one byte, flags kept
// RULE11: Clear carry or addressed bit
// RULE12: Invert all accumulator bits, flags kept
// RULE13: Invert carry or bit, latch read
// RULE14: Decimal adjust low nibble, carry only set
// RULE15: Decimal adjust high nibble, overflow untouched
// RULE16: Decimal adjust in one execute cycle
// RULE17: Decode opcode, fetch trailing bytes first
`ifndef LCB_DEFINES_SVH
`define LCB_DEFINES_SVH

`define LCB_OP_ANL_A_IMM 8'h54
`define LCB_OP_ANL_A_DIR 8'h55
`define LCB_OP_ANL_D_A 8'h52
`define LCB_OP_ANL_D_IMM 8'h53
`define LCB_OP_ANL_C_BIT 8'h82
`define LCB_OP_ANL_C_NBIT 8'hB0
`define LCB_OP_COMPARE_BRANCH_UNEQUAL_A_IMM 8'hB4
`define LCB_OP_COMPARE_BRANCH_UNEQUAL_A_DIR 8'hB5
`define LCB_OP_CLR_A 8'hE4
`define LCB_OP_CPL_A 8'hF4
`define LCB_OP_CLR_C 8'hC3
`define LCB_OP_CPL_C 8'hB3
`define LCB_OP_CLR_BIT 8'hC2
`define LCB_OP_CPL_BIT 8'hB2
`define LCB_OP_DA 8'hD4

`define LCB_ADDR_ACC 8'hE0
`define LCB_ADDR_PSW 8'hD0
`define LCB_ADDR_PORT 8'h90
`define LCB_BIT_RAM_BASE 4'h2

`define LCB_PSW_CY 7
`define LCB_PSW_AC 6
`define LCB_PSW_OV 2
`define LCB_PSW_BANK_HI 4
`define LCB_PSW_BANK_LO 3

`define LCB_RST_ACC 8'h00
`define LCB_RST_PSW 8'h00
`define LCB_RST_PORT 8'hFF
`define LCB_RST_PC 16'h0000
`define LCB_PC_COMPARE_BRANCH_UNEQUAL_STEP 16'h0003
`define LCB_BCD_FIX_LO 9'h006
`define LCB_BCD_FIX_HI 9'h060
`define LCB_BCD_MAX 4'h9

`endif

// file: lcb_pkg.sv
// Types shared by the datapath modules
package lcb_pkg;
  typedef enum logic [1:0] {LCB_FETCH, LCB_BYTE2, LCB_BYTE3} lcb_state_t;
  typedef logic [7:0] lcb_byte_t;
endpackage

// file: lcb_alu_if.sv
// Operand and result bundle between the core and its ALU
`timescale 1ns/1ps
`default_nettype none
interface lcb_alu_if;
  import lcb_pkg::*;
  lcb_byte_t opcode;
  lcb_byte_t acc;
  lcb_byte_t loc_val;
  lcb_byte_t imm;
  logic [2:0] bit_sel;
  logic cy;
  logic ac;
  lcb_byte_t acc_res;
  lcb_byte_t byte_res;
  logic cy_res;
  logic branch;
  modport core (output opcode, acc, loc_val, imm, bit_sel, cy, ac, input acc_res, byte_res, cy_res, branch);
  modport alu (input opcode, acc, loc_val, imm, bit_sel, cy, ac, output acc_res, byte_res, cy_res, branch);
endinterface
`default_nettype wire

// file: lcb_alu.sv
// Combinational results for byte AND, bit ops, compare and decimal adjust
`timescale 1ns/1ps
`default_nettype none
`include "lcb_defines.svh"
module lcb_alu
  import lcb_pkg::*;
(
  lcb_alu_if.alu a
);
  logic is_cmp_a_dir;
  logic is_cmp_a;
  lcb_byte_t cmp_x;
  lcb_byte_t cmp_y;
  logic bit_val;
  logic [8:0] da_s1;
  logic [8:0] da_s2;
  logic da_c1;
  logic da_lo_fix;
  logic da_hi_fix;

  assign is_cmp_a_dir = (a.opcode == `LCB_OP_COMPARE_BRANCH_UNEQUAL_A_DIR);
  assign is_cmp_a = is_cmp_a_dir || (a.opcode == `LCB_OP_COMPARE_BRANCH_UNEQUAL_A_IMM);
  // RULE9 operand pairs
  assign cmp_x = is_cmp_a ? a.acc : a.loc_val;
  assign cmp_y = is_cmp_a_dir ? a.loc_val : a.imm;
  // RULE7 taken only when unequal
  assign a.branch = (cmp_x != cmp_y);
  assign bit_val = a.loc_val[a.bit_sel];

  // RULE14 low nibble correction
  assign da_lo_fix = (a.acc[3:0] > `LCB_BCD_MAX) || a.ac;
  assign da_s1 = {1'b0, a.acc} + (da_lo_fix ? `LCB_BCD_FIX_LO : 9'h000);
  assign da_c1 = a.cy | da_s1[8];
  // RULE15 high nibble correction on updated carry
  assign da_hi_fix = (da_s1[7:4] > `LCB_BCD_MAX) || da_c1;
  assign da_s2 = {1'b0, da_s1[7:0]} + (da_hi_fix ? `LCB_BCD_FIX_HI : 9'h000);

  always_comb begin
    a.acc_res = a.acc;
    a.byte_res = a.loc_val;
    a.cy_res = a.cy;
    unique case (a.opcode)
      `LCB_OP_ANL_D_A: a.byte_res = a.loc_val & a.acc;
      // RULE3 immediate mask clears bits
      `LCB_OP_ANL_D_IMM: a.byte_res = a.loc_val & a.imm;
      // RULE2 immediate operand
      `LCB_OP_ANL_A_IMM: a.acc_res = a.acc & a.imm;
      // RULE5 zero bit clears carry
      `LCB_OP_ANL_C_BIT: a.cy_res = a.cy & bit_val;
      // RULE6 inverted operand, bit kept
      `LCB_OP_ANL_C_NBIT: a.cy_res = a.cy & ~bit_val;
      // RULE10 zero accumulator
      `LCB_OP_CLR_A: a.acc_res = 8'h00;
      // RULE12 one's complement
      `LCB_OP_CPL_A: a.acc_res = ~a.acc;
      // RULE11 clear carry or bit
      `LCB_OP_CLR_C: a.cy_res = 1'b0;
      `LCB_OP_CLR_BIT: a.byte_res[a.bit_sel] = 1'b0;
      // RULE13 invert carry or bit
      `LCB_OP_CPL_C: a.cy_res = ~a.cy;
      `LCB_OP_CPL_BIT: a.byte_res[a.bit_sel] = ~bit_val;
      // RULE16 one of four constants added
      `LCB_OP_DA: begin
        a.acc_res = da_s2[7:0];
        a.cy_res = da_c1 | da_s2[8];
      end
      default: begin
        // RULE1 register, direct or indirect source
        a.acc_res = a.acc & a.loc_val;
        // RULE8 unsigned less-than into carry
        if (a.opcode[7:4] == 4'hB && a.opcode[3:2] != 2'b00) begin
          a.cy_res = (cmp_x < cmp_y);
        end
      end
    endcase
  end
endmodule // lcb_alu
`default_nettype wire

// file: lcb_core.sv
// Fetch, decode and execute core for AND, bit, compare-branch, clear, invert and decimal adjust
`timescale 1ns/1ps
`default_nettype none
`include "lcb_defines.svh"
module lcb_core
  import lcb_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] prog_data,
  input wire logic [7:0] port_pins,
  output logic [15:0] prog_addr,
  output logic [7:0] port_latch,
  output logic [7:0] acc_out,
  output logic [7:0] psw_out
);
  ////////////////////////////////////////////////////////////////////////
  lcb_state_t state_q;
  lcb_state_t state_d;
  logic [15:0] pc_q;
  logic [15:0] pc_d;
  lcb_byte_t op_q;
  lcb_byte_t b2_q;
  lcb_byte_t acc_q;
  lcb_byte_t acc_d;
  lcb_byte_t psw_q;
  lcb_byte_t psw_d;
  lcb_byte_t latch_q;
  lcb_byte_t pin_s1_q;
  lcb_byte_t pin_s2_q;
  // Internal RAM, lower direct space only
  lcb_byte_t ram [0:127];

  lcb_alu_if alu_bus ();

  lcb_alu u_alu (
    .a (alu_bus.alu)
  );

  ////////////////////////////////////////////////////////////////////////
  // Current instruction bytes; the last byte is used live from the code bus
  lcb_byte_t op_w;
  lcb_byte_t b2_w;
  lcb_byte_t b3_w;
  assign op_w = (state_q == LCB_FETCH) ? prog_data : op_q;
  assign b2_w = (state_q == LCB_BYTE2) ? prog_data : b2_q;
  assign b3_w = prog_data;

  logic is_anl_rn;
  logic is_anl_ri;
  logic is_anl_dir;
  logic is_anl_imm;
  logic is_anl_da;
  logic is_anl_dimm;
  logic is_anl_cb;
  logic is_anl_cnb;
  logic is_compare_branch_unequal;
  logic is_compare_branch_unequal_rn;
  logic is_compare_branch_unequal_ri;
  logic is_clr_a;
  logic is_cpl_a;
  logic is_clr_c;
  logic is_cpl_c;
  logic is_clr_b;
  logic is_cpl_b;
  logic is_da;
  logic is_bit_op;

  // RULE17 opcode decode
  assign is_anl_rn = (op_w[7:3] == 5'b01011);
  assign is_anl_ri = (op_w[7:1] == 7'b0101011);
  assign is_anl_dir = (op_w == `LCB_OP_ANL_A_DIR);
  assign is_anl_imm = (op_w == `LCB_OP_ANL_A_IMM);
  assign is_anl_da = (op_w == `LCB_OP_ANL_D_A);
  assign is_anl_dimm = (op_w == `LCB_OP_ANL_D_IMM);
  assign is_anl_cb = (op_w == `LCB_OP_ANL_C_BIT);
  assign is_anl_cnb = (op_w == `LCB_OP_ANL_C_NBIT);
  assign is_compare_branch_unequal_rn = (op_w[7:3] == 5'b10111);
  assign is_compare_branch_unequal_ri = (op_w[7:1] == 7'b1011011);
  assign is_compare_branch_unequal = is_compare_branch_unequal_rn || is_compare_branch_unequal_ri || (op_w == `LCB_OP_COMPARE_BRANCH_UNEQUAL_A_IMM) || (op_w == `LCB_OP_COMPARE_BRANCH_UNEQUAL_A_DIR);
  assign is_clr_a = (op_w == `LCB_OP_CLR_A);
  assign is_cpl_a = (op_w == `LCB_OP_CPL_A);
  assign is_clr_c = (op_w == `LCB_OP_CLR_C);
  assign is_cpl_c = (op_w == `LCB_OP_CPL_C);
  assign is_clr_b = (op_w == `LCB_OP_CLR_BIT);
  assign is_cpl_b = (op_w == `LCB_OP_CPL_BIT);
  assign is_da = (op_w == `LCB_OP_DA);
  assign is_bit_op = is_anl_cb || is_anl_cnb || is_clr_b || is_cpl_b;

  // RULE9 compare forms are three bytes
  logic len3;
  logic len2;
  assign len3 = is_anl_dimm || is_compare_branch_unequal;
  assign len2 = is_anl_imm || is_anl_dir || is_anl_da || is_bit_op;

  // Execute on the cycle that carries the final instruction byte
  logic exec;
  assign exec = ((state_q == LCB_FETCH) && !len2 && !len3) ||
                ((state_q == LCB_BYTE2) && len2) || (state_q == LCB_BYTE3);

  ////////////////////////////////////////////////////////////////////////
  // Operand location in direct space
  logic [1:0] bank;
  lcb_byte_t ri_ptr;
  lcb_byte_t rn_loc;
  lcb_byte_t ri_loc;
  lcb_byte_t bit_loc;
  lcb_byte_t loc;
  lcb_byte_t imm;
  lcb_byte_t loc_val;
  logic rmw;
  assign bank = psw_q[`LCB_PSW_BANK_HI:`LCB_PSW_BANK_LO];
  assign ri_ptr = ram[{2'b00, bank, 2'b00, op_w[0]}];
  assign rn_loc = {3'b000, bank, op_w[2:0]};
  // Indirect reach limited to the lower 128 bytes present here
  assign ri_loc = {1'b0, ri_ptr[6:0]};
  assign bit_loc = b2_w[7] ? {b2_w[7:3], 3'b000} : {`LCB_BIT_RAM_BASE, b2_w[6:3]};
  assign loc = is_bit_op ? bit_loc :
               (is_anl_rn || is_compare_branch_unequal_rn) ? rn_loc :
               (is_anl_ri || is_compare_branch_unequal_ri) ? ri_loc : b2_w;
  assign imm = is_anl_dimm ? b3_w : b2_w;
  assign rmw = is_anl_da || is_anl_dimm || is_clr_b || is_cpl_b;

  // RULE4 port read-modify-write sees the latch
  assign loc_val = !loc[7] ? ram[loc[6:0]] :
                   (loc == `LCB_ADDR_ACC) ? acc_q :
                   (loc == `LCB_ADDR_PSW) ? psw_q :
                   (loc == `LCB_ADDR_PORT) ? (rmw ? latch_q : pin_s2_q) : 8'h00;

  assign alu_bus.opcode = op_w;
  assign alu_bus.acc = acc_q;
  assign alu_bus.loc_val = loc_val;
  assign alu_bus.imm = imm;
  assign alu_bus.bit_sel = b2_w[2:0];
  assign alu_bus.cy = psw_q[`LCB_PSW_CY];
  assign alu_bus.ac = psw_q[`LCB_PSW_AC];

  ////////////////////////////////////////////////////////////////////////
  // Write enables
  logic acc_we;
  logic byte_we;
  logic cy_we;
  logic ram_we;
  lcb_byte_t wr_val;
  assign acc_we = exec && (is_anl_rn || is_anl_ri || is_anl_dir || is_anl_imm || is_clr_a || is_cpl_a || is_da);
  // RULE3 result written to direct byte
  assign byte_we = exec && (is_anl_da || is_anl_dimm || is_clr_b || is_cpl_b);
  assign cy_we = exec && (is_anl_cb || is_anl_cnb || is_clr_c || is_cpl_c || is_compare_branch_unequal || is_da);
  assign ram_we = byte_we && !loc[7];
  assign wr_val = alu_bus.byte_res;

  // RULE1 flags untouched unless carry or PROGRAM_STATUS_WORD is the target
  assign acc_d = acc_we ? alu_bus.acc_res :
                 (byte_we && loc == `LCB_ADDR_ACC) ? wr_val : acc_q;

  always_comb begin
    psw_d = psw_q;
    if (byte_we && loc == `LCB_ADDR_PSW) begin
      psw_d = wr_val;
    end
    // RULE15 only carry moves; overflow left alone
    if (cy_we) begin
      psw_d[`LCB_PSW_CY] = alu_bus.cy_res;
    end
  end

  // RULE7 step past instruction, then displacement
  logic [15:0] rel_ext;
  assign rel_ext = {{8{b3_w[7]}}, b3_w};

  always_comb begin
    state_d = state_q;
    pc_d = pc_q + 16'h0001;
    unique case (state_q)
      LCB_FETCH: state_d = (len2 || len3) ? LCB_BYTE2 : LCB_FETCH;
      LCB_BYTE2: state_d = len3 ? LCB_BYTE3 : LCB_FETCH;
      LCB_BYTE3: begin
        state_d = LCB_FETCH;
        if (is_compare_branch_unequal && alu_bus.branch) begin
          pc_d = pc_q + 16'h0001 + rel_ext;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= LCB_FETCH;
      pc_q <= `LCB_RST_PC;
      op_q <= 8'h00;
      b2_q <= 8'h00;
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
      op_q <= op_w;
      b2_q <= b2_w;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      acc_q <= `LCB_RST_ACC;
      psw_q <= `LCB_RST_PSW;
      latch_q <= `LCB_RST_PORT;
    end else begin
      acc_q <= acc_d;
      psw_q <= psw_d;
      if (byte_we && loc == `LCB_ADDR_PORT) begin
        latch_q <= wr_val;
      end
    end
  end

  // Pins are asynchronous to the core clock
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
    end else begin
      pin_s1_q <= port_pins;
      pin_s2_q <= pin_s1_q;
    end
  end

  // RAM has no reset; software initialises it
  always_ff @(posedge clk) begin
    if (ram_we) begin
      ram[loc[6:0]] <= wr_val;
    end
  end

  assign prog_addr = pc_q;
  assign port_latch = latch_q;
  assign acc_out = acc_q;
  assign psw_out = psw_q;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic [15:0] cj_pc_exp;
  logic cj_lt;
  logic bit_val_w;
  assign bit_val_w = loc_val[b2_w[2:0]];
  assign cj_pc_exp = pc_q + 16'h0001 + (alu_bus.branch ? rel_ext : 16'h0000);
  assign cj_lt = ((op_w[7:1] == 7'b1011010) ? acc_q : loc_val) < ((op_w == `LCB_OP_COMPARE_BRANCH_UNEQUAL_A_DIR) ? loc_val : imm);

  property p_clr_acc;
    exec && is_clr_a |=> acc_q == 8'h00 && psw_q == $past(psw_q);
  endproperty
  a_clr_acc: assert property (p_clr_acc) else $error("clear acc wrong"); // RULE10

  property p_cpl_acc;
    exec && is_cpl_a |=> acc_q == ~$past(acc_q) && psw_q == $past(psw_q);
  endproperty
  a_cpl_acc: assert property (p_cpl_acc) else $error("invert acc wrong"); // RULE12

  property p_anl_acc;
    exec && (is_anl_rn || is_anl_ri || is_anl_dir) |=> acc_q == ($past(acc_q) & $past(loc_val)) && psw_q == $past(psw_q);
  endproperty
  a_anl_acc: assert property (p_anl_acc) else $error("and to acc wrong"); // RULE1

  property p_anl_imm;
    exec && is_anl_imm |=> acc_q == ($past(acc_q) & $past(prog_data));
  endproperty
  a_anl_imm: assert property (p_anl_imm) else $error("and immediate wrong"); // RULE2

  property p_anl_port;
    exec && is_anl_da && loc == `LCB_ADDR_PORT |=> port_latch == ($past(latch_q) & $past(acc_q));
  endproperty
  a_anl_port: assert property (p_anl_port) else $error("port and not from latch"); // RULE4

  property p_anl_bit;
    exec && (is_anl_cb || is_anl_cnb) |=>
      psw_q[`LCB_PSW_CY] == ($past(psw_q[`LCB_PSW_CY]) & ($past(bit_val_w) ^ $past(is_anl_cnb)));
  endproperty
  a_anl_bit: assert property (p_anl_bit) else $error("bit and carry wrong"); // RULE5

  property p_clr_c;
    exec && is_clr_c |=> !psw_q[`LCB_PSW_CY] && psw_q[6:0] == $past(psw_q[6:0]);
  endproperty
  a_clr_c: assert property (p_clr_c) else $error("clear carry wrong"); // RULE11

  property p_cpl_c;
    exec && is_cpl_c |=> psw_q[`LCB_PSW_CY] != $past(psw_q[`LCB_PSW_CY]);
  endproperty
  a_cpl_c: assert property (p_cpl_c) else $error("invert carry wrong"); // RULE13

  property p_compare_branch_unequal_pc;
    exec && is_compare_branch_unequal |=> pc_q == $past(cj_pc_exp);
  endproperty
  a_compare_branch_unequal_pc: assert property (p_compare_branch_unequal_pc) else $error("compare branch pc wrong"); // RULE7

  property p_compare_branch_unequal_cy;
    exec && is_compare_branch_unequal |=> psw_q[`LCB_PSW_CY] == $past(cj_lt) && acc_q == $past(acc_q);
  endproperty
  a_compare_branch_unequal_cy: assert property (p_compare_branch_unequal_cy) else $error("compare carry wrong"); // RULE8

  property p_compare_branch_unequal_len;
    state_q == LCB_FETCH && is_compare_branch_unequal |=> state_q == LCB_BYTE2 ##1 state_q == LCB_BYTE3 ##1 state_q == LCB_FETCH;
  endproperty
  a_compare_branch_unequal_len: assert property (p_compare_branch_unequal_len) else $error("compare length wrong"); // RULE9

  property p_da_cy;
    exec && is_da && psw_q[`LCB_PSW_CY] |=> psw_q[`LCB_PSW_CY] && psw_q[`LCB_PSW_OV] == $past(psw_q[`LCB_PSW_OV]);
  endproperty
  a_da_cy: assert property (p_da_cy) else $error("adjust cleared carry"); // RULE14

  property p_da_one;
    state_q == LCB_FETCH && is_da |=> state_q == LCB_FETCH && pc_q == $past(pc_q) + 16'h0001;
  endproperty
  a_da_one: assert property (p_da_one) else $error("adjust not single cycle"); // RULE16

  property p_da_hi;
    exec && is_da && $unsigned(acc_q[7:4]) > 4'h9 && acc_q[3:0] < 4'h9 && !psw_q[`LCB_PSW_AC] |=> psw_q[`LCB_PSW_CY];
  endproperty
  a_da_hi: assert property (p_da_hi) else $error("adjust high carry missing"); // RULE15
endmodule // lcb_core
`default_nettype wire

// file: logic_compare_bcd_ops_tb.sv
// Self-checking testbench for the logic, compare and decimal adjust core
`timescale 1ns/1ps
`default_nettype none
`include "lcb_defines.svh"
module logic_compare_bcd_ops_tb
  import lcb_pkg::*;
;
  logic clk;
  logic reset;
  lcb_byte_t prog_data;
  lcb_byte_t port_pins;
  logic [15:0] prog_addr;
  lcb_byte_t port_latch;
  lcb_byte_t acc_out;
  lcb_byte_t psw_out;
  int error_cnt;
  int check_count;
  logic [15:0] exp_pc;

  lcb_core DUT (
    .clk(clk),
    .reset(reset),
    .prog_data(prog_data),
    .port_pins(port_pins),
    .prog_addr(prog_addr),
    .port_latch(port_latch),
    .acc_out(acc_out),
    .psw_out(psw_out)
  );

  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk8(input lcb_byte_t got, input lcb_byte_t exp, input string what);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Bytes go out on falling edges with no idle gap; the core eats one per edge
  task automatic op(input lcb_byte_t b0, input lcb_byte_t b1, input lcb_byte_t b2, input int n,
                    input logic [15:0] jmp);
    lcb_byte_t b [3];
    b = '{b0, b1, b2};
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      prog_data = b[i];
    end
    @(posedge clk);
    #1;
    exp_pc = exp_pc + 16'(n) + jmp;
    chk16(prog_addr, exp_pc, "program counter");
  endtask

  task automatic op1(input lcb_byte_t b0);
    op(b0, 8'h00, 8'h00, 1, 16'h0000);
  endtask

  // No load instruction here, so clear, invert, then mask in the value
  task automatic set_acc(input lcb_byte_t v);
    op1(`LCB_OP_CLR_A);
    op1(`LCB_OP_CPL_A);
    op(`LCB_OP_ANL_A_IMM, v, 8'h00, 2, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // accumulator clear and invert
  task automatic t_acc_ops();
    op1(`LCB_OP_CPL_C);
    chk8(psw_out, 8'h80, "status");
    op1(`LCB_OP_CPL_A);
    chk8(acc_out, 8'hFF, "acc");
    chk8(psw_out, 8'h80, "status");
    op1(`LCB_OP_CLR_A);
    chk8(acc_out, 8'h00, "acc");
    chk8(psw_out, 8'h80, "status");
    op1(`LCB_OP_CPL_C);
  endtask

  task automatic t_anl_acc();
    set_acc(8'hC3);
    chk8(acc_out, 8'hC3, "acc");
    op(`LCB_OP_ANL_A_DIR, `LCB_ADDR_PORT, 8'h00, 2, 16'h0000);
    chk8(acc_out, 8'h42, "acc");
    op1(`LCB_OP_CPL_C);
    op(`LCB_OP_ANL_A_DIR, `LCB_ADDR_PSW, 8'h00, 2, 16'h0000);
    chk8(acc_out, 8'h00, "acc");
    chk8(psw_out, 8'h80, "status");
    op1(`LCB_OP_CPL_C);
  endtask

  // AND into direct byte, port from latch
  task automatic t_anl_dir();
    op(`LCB_OP_ANL_D_IMM, `LCB_ADDR_PORT, 8'h73, 3, 16'h0000);
    chk8(port_latch, 8'h73, "latch");
    set_acc(8'h0F);
    op(`LCB_OP_ANL_D_A, `LCB_ADDR_PORT, 8'h00, 2, 16'h0000);
    chk8(port_latch, 8'h03, "latch");
    op(`LCB_OP_ANL_D_IMM, `LCB_ADDR_ACC, 8'h06, 3, 16'h0000);
    chk8(acc_out, 8'h06, "acc");
  endtask

  task automatic t_bits();
    op1(`LCB_OP_CPL_C);
    op(`LCB_OP_ANL_C_BIT, 8'hE1, 8'h00, 2, 16'h0000);
    chk8(psw_out, 8'h80, "status");
    op(`LCB_OP_ANL_C_NBIT, 8'hE0, 8'h00, 2, 16'h0000);
    chk8(psw_out, 8'h80, "status");
    op(`LCB_OP_ANL_C_NBIT, 8'hE1, 8'h00, 2, 16'h0000);
    chk8(psw_out, 8'h00, "status");
    chk8(acc_out, 8'h06, "acc");
    op1(`LCB_OP_CPL_C);
    op(`LCB_OP_ANL_C_BIT, 8'hE0, 8'h00, 2, 16'h0000);
    chk8(psw_out, 8'h00, "status");
    op1(`LCB_OP_CPL_C);
    op1(`LCB_OP_CLR_C);
    chk8(psw_out, 8'h00, "status");
    op(`LCB_OP_CLR_BIT, 8'h91, 8'h00, 2, 16'h0000);
    chk8(port_latch, 8'h01, "latch");
    // Pin bit 3 is high, latch bit 3 low: only a latch read gives 1
    op(`LCB_OP_CPL_BIT, 8'h93, 8'h00, 2, 16'h0000);
    chk8(port_latch, 8'h09, "latch");
    op(`LCB_OP_CPL_BIT, 8'hD6, 8'h00, 2, 16'h0000);
    chk8(psw_out, 8'h40, "status");
    op(`LCB_OP_CLR_BIT, 8'hD6, 8'h00, 2, 16'h0000);
    chk8(psw_out, 8'h00, "status");
  endtask

  task automatic t_compare_branch_unequal();
    set_acc(8'h34);
    op(`LCB_OP_COMPARE_BRANCH_UNEQUAL_A_IMM, 8'h56, 8'h05, 3, 16'h0005);
    chk8(psw_out, 8'h80, "carry on less");
    op(`LCB_OP_COMPARE_BRANCH_UNEQUAL_A_IMM, 8'h34, 8'h05, 3, 16'h0000);
    chk8(psw_out, 8'h00, "carry on equal");
    op(`LCB_OP_COMPARE_BRANCH_UNEQUAL_A_IMM, 8'h12, 8'hFE, 3, 16'hFFFE);
    chk8(psw_out, 8'h00, "carry on greater");
    op(`LCB_OP_COMPARE_BRANCH_UNEQUAL_A_DIR, `LCB_ADDR_PORT, 8'h10, 3, 16'h0010);
    chk8(psw_out, 8'h80, "carry direct");
    chk8(acc_out, 8'h34, "acc kept");
    set_acc(8'h5A);
    op(`LCB_OP_COMPARE_BRANCH_UNEQUAL_A_DIR, `LCB_ADDR_PORT, 8'h10, 3, 16'h0000);
    chk8(psw_out, 8'h00, "carry direct");
    // Unsigned: a signed compare would clear carry here
    op(`LCB_OP_COMPARE_BRANCH_UNEQUAL_A_IMM, 8'hFF, 8'h80, 3, 16'hFF80);
    chk8(psw_out, 8'h80, "carry unsigned");
  endtask

  // register and indirect forms; a mask can only plant zero in RAM
  task automatic t_regs();
    op(`LCB_OP_ANL_D_IMM, 8'h07, 8'h00, 3, 16'h0000);
    op(`LCB_OP_ANL_D_IMM, 8'h00, 8'h00, 3, 16'h0000);
    op(8'hBF, 8'h01, 8'h04, 3, 16'h0004);
    chk8(psw_out, 8'h80, "carry register");
    op(8'hB6, 8'h00, 8'h04, 3, 16'h0000);
    chk8(psw_out, 8'h00, "carry indirect");
    op1(8'h5F);
    chk8(acc_out, 8'h00, "acc register");
  endtask

  task automatic da_case(input lcb_byte_t v, input logic cy, input logic ac, input logic ov,
                         input lcb_byte_t exp_a, input logic exp_cy);
    op(`LCB_OP_ANL_D_IMM, `LCB_ADDR_PSW, 8'h00, 3, 16'h0000);
    set_acc(v);
    if (cy) begin
      op1(`LCB_OP_CPL_C);
    end
    if (ac) begin
      op(`LCB_OP_CPL_BIT, 8'hD6, 8'h00, 2, 16'h0000);
    end
    if (ov) begin
      op(`LCB_OP_CPL_BIT, 8'hD2, 8'h00, 2, 16'h0000);
    end
    op1(`LCB_OP_DA);
    chk8(acc_out, exp_a, "adjusted acc");
    chk8(psw_out & 8'h84, {exp_cy, 4'h0, ov, 2'h0}, "carry and overflow");
  endtask

  task automatic t_da();
    da_case(8'h12, 1'b0, 1'b0, 1'b0, 8'h12, 1'b0);
    da_case(8'h29, 1'b0, 1'b1, 1'b0, 8'h2F, 1'b0);
    da_case(8'h12, 1'b1, 1'b0, 1'b1, 8'h72, 1'b1);
    da_case(8'hBE, 1'b0, 1'b0, 1'b0, 8'h24, 1'b1);
    da_case(8'h9F, 1'b0, 1'b0, 1'b0, 8'h05, 1'b1);
    da_case(8'hFA, 1'b0, 1'b0, 1'b0, 8'h60, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    error_cnt = 0;
    check_count = 0;
    reset = 1'b1;
    prog_data = 8'h00;
    port_pins = 8'h5A;
    exp_pc = 16'h0001;
    repeat (12) @(negedge clk);
    chk16(prog_addr, 16'h0000, "reset pc");
    chk8(acc_out, 8'h00, "reset acc");
    chk8(psw_out, 8'h00, "reset status");
    chk8(port_latch, 8'hFF, "reset latch");
    reset = 1'b0;
    t_acc_ops();
    t_anl_acc();
    t_anl_dir();
    t_bits();
    t_compare_branch_unequal();
    t_regs();
    t_da();
    finish_test();
  end

  // Whole run is about 150 cycles; this is a generous margin
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    $display("[ERR] %0t: watchdog expired", $time);
    finish_test();
  end
endmodule // logic_compare_bcd_ops_tb
`default_nettype wire
